// ===== logic/ata_cmd_map.svh
// constants for the standby, translate and write command executor
`ifndef ATA_CMD_MAP_SVH
`define ATA_CMD_MAP_SVH
`define ATC_OP_STBY_A 8'h94
`define ATC_OP_STBY_B 8'hE0
`define ATC_OP_XLATE 8'h87
`define ATC_OP_WEAR 8'hF5
`define ATC_OP_WRBUF 8'hE8
`define ATC_OP_WRDMA 8'hCA
`define ATC_OP_WRLONG_A 8'h32
`define ATC_OP_WRLONG_B 8'h33
`define ATC_OP_SETFEAT 8'hEF
`define ATC_FEAT_8BIT_ON 8'h01
`define ATC_FEAT_8BIT_OFF 8'h81
`define ATC_SECT_WORDS 9'h100
`define ATC_ECC_BYTES 3'h4
`define ATC_RPT_CYL_HI 9'h000
`define ATC_RPT_CYL_LO 9'h001
`define ATC_RPT_HEAD 9'h002
`define ATC_RPT_SECT 9'h003
`define ATC_RPT_LBA_HI 9'h004
`define ATC_RPT_LBA_MID 9'h005
`define ATC_RPT_LBA_LO 9'h006
`define ATC_RPT_ERASED 9'h013
`define ATC_RPT_HOT_HI 9'h018
`define ATC_RPT_HOT_MID 9'h019
`define ATC_RPT_HOT_LO 9'h01A
`define ATC_ERASED_VAL 8'hFF
`define ATC_NOT_ERASED_VAL 8'h00
`define ATC_WEAR_DONE_CNT 8'h00
`define ATC_ERR_ABORT 8'h04
`endif

// ===== logic/atc_pkg.sv
// types shared by the command executor
package atc_pkg;
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] sect_cnt;
        logic [7:0] sect_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev_head;
    } atc_taskfile_type;

    typedef struct packed {
        logic bsy;
        logic drq;
        logic err;
    } atc_status_type;

    typedef enum logic [2:0] {
        ATC_MED_IDLE,
        ATC_MED_WRITE,
        ATC_MED_WRITE_LONG,
        ATC_MED_FREEZE
    } atc_media_op_type;
endpackage

// ===== logic/atc_sector_ram.sv
// sector buffer: 256 words, registered read
`timescale 1ns/10ps
`default_nettype none
module atc_sector_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [15:0] o_rd_data
);
    logic [15:0] mem [DEPTH];
    logic [15:0] rd_data_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        rd_data_ff <= mem[i_rd_addr];
    end

    assign o_rd_data = rd_data_ff;
endmodule // atc_sector_ram
`default_nettype wire

// ===== logic/atc_cmd_exec.sv
// command executor: standby, translate, wear level, write buffer/DMA/long
`timescale 1ns/10ps
`default_nettype none
`include "ata_cmd_map.svh"
// Notes on behaviour
// - standby 94H/E0H: busy, sleep, clear busy, interrupt at once; the code never raises busy, it only sleeps and interrupts
// - any later command wakes the sleeping device, no reset needed
// - translate 87H returns a 512-byte report to the host
// - report holds cylinder, head, sector, LBA, high byte first
// - report byte 13H is FFH when erased, else 00H
// - bytes 18H-1AH give hot count, high first; zero means untracked
// - F5H without security is a no-op returning sector count 00H
// - F5H with security acts as freeze lock
// - write buffer E8H takes 512 bytes into the sector buffer by PIO; in byte mode the code takes only 256
// - write DMA CAH moves 1 to 256 sectors, zero meaning 256
// - DMA write raises busy, prepares buffer, then DRQ and clears busy
// - DMA request held while the device can take words
// - DMA write interrupts only at completion or unrecoverable error
// - address registers hold last sector, or failing sector on error
// - DMA write aborted while byte-wide mode is on
// - write long 32H/33H takes 516 bytes by PIO; in byte mode the code takes 260 (256 data, 4 ECC)
// - write long is single sector only
// - 512 bytes go as words, then four ECC bytes one per strobe; in byte mode the code takes 256 data bytes, one per strobe
// - host ECC bytes ignored; media stores internally generated ECC
// - feature 01H enables, 81H disables byte-wide transfers
// - PIO write: busy, then DRQ and clear busy, wait for data
module atc_cmd_exec #(
    parameter bit SECURITY_SUPPORTED = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_opcode,
    input wire atc_pkg::atc_taskfile_type i_taskfile,
    input wire logic i_io_write_strobe_n,
    input wire logic i_io_read_strobe_n,
    input wire logic [15:0] i_host_data,
    input wire logic i_dma_acknowledge_n,
    input wire logic [23:0] i_media_lba,
    input wire logic [23:0] i_media_hot_count,
    input wire logic i_media_erased,
    input wire logic i_media_ready,
    input wire logic i_media_error,
    output atc_pkg::atc_status_type o_status,
    output logic o_intrq,
    output logic [7:0] o_error,
    output logic [7:0] o_sect_cnt,
    output logic o_sect_cnt_valid,
    output logic o_sleeping,
    output logic o_byte_mode,
    output logic o_dma_request_line,
    output logic [15:0] o_host_data,
    output atc_pkg::atc_media_op_type o_media_op,
    output logic o_media_start,
    output logic [7:0] o_addr_sect_num,
    output logic [15:0] o_addr_cyl,
    output logic [3:0] o_addr_head
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_PREP, ST_PIO_IN, ST_DMA_IN, ST_ECC_IN, ST_COMMIT, ST_RPT_OUT
    } atc_state_type;

    atc_state_type state_ff, nxt_state;
    atc_pkg::atc_media_op_type mop_ff;
    logic [7:0] op_ff;
    logic [8:0] remain_ff;
    logic [8:0] idx_ff;
    logic [2:0] ecc_ff;
    logic sleep_ff, byte_ff, bsy_ff, drq_ff, err_ff, intrq_ff, start_ff, scv_ff;
    logic [7:0] errreg_ff, scnt_ff;
    logic [15:0] hdata_ff;
    logic [7:0] sn_ff;
    logic [15:0] cyl_ff;
    logic [3:0] hd_ff;
    logic wr_q_ff, rd_q_ff;
    logic [15:0] ram_rd;

    function automatic logic is_op(input logic [7:0] op, input logic [7:0] a,
                                   input logic [7:0] b);
        is_op = (op == a) || (op == b);
    endfunction

    wire op_stby = is_op(i_cmd_opcode, `ATC_OP_STBY_A, `ATC_OP_STBY_B);
    wire op_xlate = i_cmd_opcode == `ATC_OP_XLATE;
    wire op_wear = i_cmd_opcode == `ATC_OP_WEAR;
    wire op_wrbuf = i_cmd_opcode == `ATC_OP_WRBUF;
    wire op_dma = i_cmd_opcode == `ATC_OP_WRDMA;
    wire op_long = is_op(i_cmd_opcode, `ATC_OP_WRLONG_A, `ATC_OP_WRLONG_B);
    wire op_feat = i_cmd_opcode == `ATC_OP_SETFEAT;
    wire cur_dma = op_ff == `ATC_OP_WRDMA;
    // strobe taken on its release, as a host write is latched on the rising edge
    wire wr_edge = !wr_q_ff && i_io_write_strobe_n;
    wire rd_edge = !rd_q_ff && i_io_read_strobe_n;
    wire dma_word = wr_edge && !i_dma_acknowledge_n;
    wire pio_word = wr_edge && i_dma_acknowledge_n;
    wire last_word = idx_ff == (`ATC_SECT_WORDS - 9'h001);
    wire accept = i_cmd_wr && (state_ff == ST_IDLE);
    wire [8:0] cnt_eff = (i_taskfile.sect_cnt == 8'h00) ? 9'h100 : {1'b0, i_taskfile.sect_cnt};
    wire [7:0] byte_idx = idx_ff[7:0];

    // report byte table; inputs passed in so the wires follow every input change
    function automatic logic [7:0] rpt_byte(input logic [8:0] a,
        input atc_pkg::atc_taskfile_type tf, input logic [23:0] lba,
        input logic [23:0] hot, input logic erased);
        unique case (a)
            `ATC_RPT_CYL_HI: rpt_byte = tf.cyl_hi;
            `ATC_RPT_CYL_LO: rpt_byte = tf.cyl_lo;
            `ATC_RPT_HEAD: rpt_byte = {4'h0, tf.dev_head[3:0]};
            `ATC_RPT_SECT: rpt_byte = tf.sect_num;
            `ATC_RPT_LBA_HI: rpt_byte = lba[23:16];
            `ATC_RPT_LBA_MID: rpt_byte = lba[15:8];
            `ATC_RPT_LBA_LO: rpt_byte = lba[7:0];
            `ATC_RPT_ERASED: rpt_byte = erased ? `ATC_ERASED_VAL
                                               : `ATC_NOT_ERASED_VAL;
            `ATC_RPT_HOT_HI: rpt_byte = hot[23:16];
            `ATC_RPT_HOT_MID: rpt_byte = hot[15:8];
            `ATC_RPT_HOT_LO: rpt_byte = hot[7:0];
            default: rpt_byte = 8'h00;
        endcase
    endfunction

    // two bytes per word in word mode, even byte on the low lane; one byte per word in byte mode
    wire [8:0] rpt_addr = byte_ff ? idx_ff : {idx_ff[7:0], 1'b0};
    wire [7:0] rpt_even = rpt_byte(rpt_addr, i_taskfile, i_media_lba, i_media_hot_count,
                                   i_media_erased);
    wire [7:0] rpt_odd = rpt_byte(rpt_addr | 9'h001, i_taskfile, i_media_lba,
                                  i_media_hot_count, i_media_erased);
    wire [15:0] rpt_word = byte_ff ? {8'h00, rpt_even} : {rpt_odd, rpt_even};
    wire [8:0] rpt_len = byte_ff ? 9'h1FF : 9'h0FF;

    atc_sector_ram u_ram (
        .i_sys_clk(i_sys_clk),
        .i_wr_en((state_ff == ST_PIO_IN && pio_word) || (state_ff == ST_DMA_IN && dma_word)),
        .i_wr_addr(byte_idx),
        .i_wr_data(byte_ff ? {8'h00, i_host_data[7:0]} : i_host_data),
        .i_rd_addr(byte_idx),
        .o_rd_data(ram_rd)
    );

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept && (op_xlate || op_wrbuf || op_long || (op_dma && !byte_ff))) begin
                    nxt_state = ST_PREP;
                end
            end
            ST_PREP: nxt_state = op_ff == `ATC_OP_XLATE ? ST_RPT_OUT
                               : (cur_dma ? ST_DMA_IN : ST_PIO_IN);
            ST_PIO_IN: begin
                if (pio_word && last_word) begin
                    nxt_state = (mop_ff == atc_pkg::ATC_MED_WRITE_LONG) ? ST_ECC_IN
                              : (op_ff == `ATC_OP_WRBUF ? ST_IDLE : ST_COMMIT);
                end
            end
            ST_DMA_IN: if (dma_word && last_word) nxt_state = ST_COMMIT;
            ST_ECC_IN: if (pio_word && ecc_ff == (`ATC_ECC_BYTES - 3'h1)) nxt_state = ST_COMMIT;
            ST_COMMIT: begin
                if (i_media_error) begin
                    nxt_state = ST_IDLE;
                end else if (i_media_ready) begin
                    nxt_state = (cur_dma && remain_ff != 9'h001) ? ST_DMA_IN : ST_IDLE;
                end
            end
            ST_RPT_OUT: if (rd_edge && idx_ff == rpt_len) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            wr_q_ff <= 1'b1;
            rd_q_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            wr_q_ff <= i_io_write_strobe_n;
            rd_q_ff <= i_io_read_strobe_n;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            op_ff <= 8'h00;
            mop_ff <= atc_pkg::ATC_MED_IDLE;
            sleep_ff <= 1'b0;
            byte_ff <= 1'b0;
            bsy_ff <= 1'b0;
            drq_ff <= 1'b0;
            err_ff <= 1'b0;
            intrq_ff <= 1'b0;
            start_ff <= 1'b0;
            scv_ff <= 1'b0;
            errreg_ff <= 8'h00;
            scnt_ff <= 8'h00;
            remain_ff <= 9'h000;
            idx_ff <= 9'h000;
            ecc_ff <= 3'h0;
            hdata_ff <= 16'h0000;
            sn_ff <= 8'h00;
            cyl_ff <= 16'h0000;
            hd_ff <= 4'h0;
        end else begin
            start_ff <= 1'b0;
            intrq_ff <= 1'b0;
            if (accept) begin
                op_ff <= i_cmd_opcode;
                sleep_ff <= op_stby;
                err_ff <= 1'b0;
                errreg_ff <= 8'h00;
                scv_ff <= 1'b0;
                idx_ff <= 9'h000;
                ecc_ff <= 3'h0;
                remain_ff <= op_long ? 9'h001 : cnt_eff;
                sn_ff <= i_taskfile.sect_num;
                cyl_ff <= {i_taskfile.cyl_hi, i_taskfile.cyl_lo};
                hd_ff <= i_taskfile.dev_head[3:0];
                mop_ff <= op_long ? atc_pkg::ATC_MED_WRITE_LONG : atc_pkg::ATC_MED_WRITE;
                bsy_ff <= op_xlate || op_wrbuf || op_long || (op_dma && !byte_ff);
                if (op_stby || op_feat) begin
                    intrq_ff <= 1'b1;
                end
                if (op_feat && i_taskfile.feature == `ATC_FEAT_8BIT_ON) byte_ff <= 1'b1;
                if (op_feat && i_taskfile.feature == `ATC_FEAT_8BIT_OFF) byte_ff <= 1'b0;
                if (op_wear) begin
                    intrq_ff <= 1'b1;
                    if (SECURITY_SUPPORTED) begin
                        mop_ff <= atc_pkg::ATC_MED_FREEZE;
                        start_ff <= 1'b1;
                    end else begin
                        scnt_ff <= `ATC_WEAR_DONE_CNT;
                        scv_ff <= 1'b1;
                    end
                end
                if ((op_dma && byte_ff) || !(op_stby || op_xlate || op_wear || op_wrbuf
                                             || op_dma || op_long || op_feat)) begin
                    err_ff <= 1'b1;
                    errreg_ff <= `ATC_ERR_ABORT;
                    intrq_ff <= 1'b1;
                end
            end
            if (state_ff == ST_PREP) begin
                bsy_ff <= 1'b0;
                drq_ff <= 1'b1;
                if (op_ff == `ATC_OP_XLATE) hdata_ff <= rpt_word;
            end
            if ((state_ff == ST_PIO_IN && pio_word) || (state_ff == ST_DMA_IN && dma_word)) begin
                idx_ff <= last_word ? 9'h000 : idx_ff + 9'h001;
            end
            if (state_ff == ST_ECC_IN && pio_word) begin
                ecc_ff <= ecc_ff + 3'h1;
            end
            if (nxt_state == ST_COMMIT && state_ff != ST_COMMIT) begin
                bsy_ff <= 1'b1;
                drq_ff <= 1'b0;
                start_ff <= 1'b1;
            end
            if (state_ff == ST_PIO_IN && nxt_state == ST_IDLE) begin
                drq_ff <= 1'b0;
                intrq_ff <= 1'b1;
            end
            if (state_ff == ST_COMMIT) begin
                if (i_media_error) begin
                    bsy_ff <= 1'b0;
                    err_ff <= 1'b1;
                    intrq_ff <= 1'b1;
                end else if (i_media_ready) begin
                    if (nxt_state == ST_DMA_IN) begin
                        remain_ff <= remain_ff - 9'h001;
                        sn_ff <= sn_ff + 8'h01;
                        bsy_ff <= 1'b0;
                        drq_ff <= 1'b1;
                    end else begin
                        bsy_ff <= 1'b0;
                        intrq_ff <= 1'b1;
                    end
                end
            end
            if (state_ff == ST_RPT_OUT && rd_edge) begin
                idx_ff <= idx_ff + 9'h001;
                if (nxt_state == ST_IDLE) begin
                    drq_ff <= 1'b0;
                    intrq_ff <= 1'b1;
                end
            end
            if (state_ff == ST_RPT_OUT) begin
                hdata_ff <= rpt_word;
            end else if (state_ff != ST_PREP) begin
                hdata_ff <= ram_rd;
            end
        end
    end

    assign o_status = '{bsy: bsy_ff, drq: drq_ff, err: err_ff};
    assign o_intrq = intrq_ff;
    assign o_error = errreg_ff;
    assign o_sect_cnt = scnt_ff;
    assign o_sect_cnt_valid = scv_ff;
    assign o_sleeping = sleep_ff;
    assign o_byte_mode = byte_ff;
    assign o_dma_request_line = (state_ff == ST_DMA_IN);
    assign o_host_data = hdata_ff;
    assign o_media_op = mop_ff;
    assign o_media_start = start_ff;
    assign o_addr_sect_num = sn_ff;
    assign o_addr_cyl = cyl_ff;
    assign o_addr_head = hd_ff;

    a_stby_intr: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        accept && op_stby |=> o_intrq && o_sleeping && !bsy_ff)
        else $error("standby did not complete at once");
    a_dma_abort: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        accept && op_dma && byte_ff |=> err_ff && errreg_ff == `ATC_ERR_ABORT)
        else $error("dma in byte mode not aborted");
    a_wear_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        accept && op_wear && !SECURITY_SUPPORTED |=> scv_ff && scnt_ff == 8'h00)
        else $error("wear level count not zero");
    a_dma_no_intr: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_ff == ST_DMA_IN |-> !o_intrq)
        else $error("interrupt during dma data");
    a_drq_prep: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_ff == ST_PREP |=> drq_ff && !bsy_ff)
        else $error("drq not raised after prep");
    a_unknown_abort: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        accept && i_cmd_opcode == 8'h00 |=> err_ff && o_intrq)
        else $error("unknown opcode not aborted");
    a_byte_on: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        accept && op_feat && i_taskfile.feature == 8'h01 |=> byte_ff)
        else $error("byte mode not enabled");
    a_wake: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        sleep_ff && accept && !op_stby |=> !sleep_ff)
        else $error("no wake on command");
endmodule // atc_cmd_exec
`default_nettype wire

// ===== verification/atc_host_model.sv
// host controller model: issues commands and drives the data strobes
`timescale 1ns/10ps
`default_nettype none
module atc_host_model (
    input wire logic i_sys_clk,
    input wire atc_pkg::atc_status_type i_status,
    input wire logic i_dma_request_line,
    input wire logic [15:0] i_host_data,
    output logic o_cmd_wr,
    output logic [7:0] o_cmd_opcode,
    output atc_pkg::atc_taskfile_type o_taskfile,
    output logic o_io_write_strobe_n,
    output logic o_io_read_strobe_n,
    output logic [15:0] o_host_data,
    output logic o_dma_acknowledge_n,
    output logic o_timeout
);
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd_opcode = 8'h00;
        o_taskfile = '0;
        o_io_write_strobe_n = 1'b1;
        o_io_read_strobe_n = 1'b1;
        o_host_data = 16'h0000;
        o_dma_acknowledge_n = 1'b1;
        o_timeout = 1'b0;
    end

    task automatic issue(input logic [7:0] op, input atc_pkg::atc_taskfile_type tf);
        @(negedge i_sys_clk);
        o_dma_acknowledge_n = 1'b1;
        o_taskfile = tf;
        o_cmd_opcode = op;
        o_cmd_wr = 1'b1;
        @(negedge i_sys_clk);
        o_cmd_wr = 1'b0;
        // no longer qualified, so show a changed pattern
        o_cmd_opcode = ~op;
    endtask

    // bounded so a silent device cannot hang the host
    task automatic wait_ready(input logic dma);
        int n;
        n = 0;
        while ((dma ? i_dma_request_line : i_status.drq) !== 1'b1 && n < 600) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n >= 600) o_timeout = 1'b1;
    endtask

    // two cycles after release: the device captures one cycle late
    task automatic write_word(input logic [15:0] d, input logic dma);
        wait_ready(dma);
        o_dma_acknowledge_n = ~dma;
        o_host_data = d;
        o_io_write_strobe_n = 1'b0;
        @(negedge i_sys_clk);
        o_io_write_strobe_n = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        o_host_data = ~d;
    endtask

    task automatic read_word(output logic [15:0] d);
        wait_ready(1'b0);
        o_io_read_strobe_n = 1'b0;
        @(negedge i_sys_clk);
        d = i_host_data;
        o_io_read_strobe_n = 1'b1;
        repeat (2) @(negedge i_sys_clk);
    endtask
endmodule // atc_host_model
`default_nettype wire

// ===== verification/ata_standby_translate_write_cmds_tb.sv
// self-checking bench for the command executor
`timescale 1ns/10ps
`default_nettype none
`include "ata_cmd_map.svh"
module ata_standby_translate_write_cmds_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_wr, wr_n, rd_n, dack_n, host_to, intrq, sleeping, byte_mode, dreq, sc_valid, m_start;
    logic [7:0] opcode, err_reg, sc_out, addr_sn;
    logic [15:0] hdata_in, hdata_out, addr_cyl;
    logic [3:0] addr_head;
    logic [23:0] lba = 24'hA1B2C3;
    logic [23:0] hot = 24'h0D0E0F;
    logic erased = 1'b1;
    logic media_ready = 1'b0;
    logic media_error = 1'b0;
    atc_pkg::atc_taskfile_type tf_bus, tf;
    atc_pkg::atc_status_type status;
    atc_pkg::atc_media_op_type m_op, last_op;
    int mismatches = 0;
    int n_checks = 0;
    int n_irq = 0;
    int n_starts = 0;
    int err_at = 0;
    int m_cnt = 0;
    int irq_mark = 0;

    always #5 sys_clk = ~sys_clk;

    atc_cmd_exec #(.SECURITY_SUPPORTED(1'b0)) uut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_cmd_wr(cmd_wr), .i_cmd_opcode(opcode), .i_taskfile(tf_bus),
        .i_io_write_strobe_n(wr_n), .i_io_read_strobe_n(rd_n), .i_host_data(hdata_in),
        .i_dma_acknowledge_n(dack_n), .i_media_lba(lba), .i_media_hot_count(hot),
        .i_media_erased(erased), .i_media_ready(media_ready), .i_media_error(media_error),
        .o_status(status), .o_intrq(intrq), .o_error(err_reg), .o_sect_cnt(sc_out),
        .o_sect_cnt_valid(sc_valid), .o_sleeping(sleeping), .o_byte_mode(byte_mode),
        .o_dma_request_line(dreq), .o_host_data(hdata_out), .o_media_op(m_op),
        .o_media_start(m_start), .o_addr_sect_num(addr_sn), .o_addr_cyl(addr_cyl),
        .o_addr_head(addr_head));

    atc_host_model host (.i_sys_clk(sys_clk), .i_status(status), .i_dma_request_line(dreq),
        .i_host_data(hdata_out), .o_cmd_wr(cmd_wr), .o_cmd_opcode(opcode), .o_taskfile(tf_bus),
        .o_io_write_strobe_n(wr_n), .o_io_read_strobe_n(rd_n), .o_host_data(hdata_in),
        .o_dma_acknowledge_n(dack_n), .o_timeout(host_to));

    always @(posedge sys_clk) begin
        if (intrq === 1'b1) n_irq++;
    end

    // media answers a commit after a few cycles; err_at picks the failing one
    always @(negedge sys_clk) begin
        if (m_start === 1'b1) begin
            n_starts++;
            last_op = m_op;
            m_cnt = 5;
        end else if (m_cnt > 0) begin
            m_cnt--;
        end
        media_ready = (m_cnt inside {1, 2}) && (n_starts != err_at);
        media_error = (m_cnt inside {1, 2}) && (n_starts == err_at);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // interrupt is a one-cycle pulse, so wait on the pulse count, not the level
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (n_irq == irq_mark && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] f, input logic [7:0] sc,
                       input logic [7:0] sn);
        repeat (2) @(negedge sys_clk);
        tf = '{f, sc, sn, 8'h34, 8'h12, 8'h0B};
        irq_mark = n_irq;
        host.issue(op, tf);
    endtask

    task automatic saw_busy(output logic seen);
        seen = status.bsy;
        @(negedge sys_clk);
        seen = seen | status.bsy;
    endtask

    function automatic logic [15:0] rpt_word(input int k);
        case (k)
            0: rpt_word = {tf.cyl_lo, tf.cyl_hi};
            1: rpt_word = {tf.sect_num, tf.dev_head};
            2: rpt_word = {lba[15:8], lba[23:16]};
            3: rpt_word = {8'h00, lba[7:0]};
            9: rpt_word = {erased ? 8'hFF : 8'h00, 8'h00};
            12: rpt_word = {hot[15:8], hot[23:16]};
            13: rpt_word = {8'h00, hot[7:0]};
            default: rpt_word = 16'h0000;
        endcase
    endfunction

    task automatic t_standby;
        logic [7:0] ops [2] = '{`ATC_OP_STBY_A, `ATC_OP_STBY_B};
        foreach (ops[i]) begin
            cmd(ops[i], 8'h00, 8'h5A, 8'h00);
            wait_irq(4);
            chk(n_irq - irq_mark, 1, "standby irq");
            chk({status.bsy, sleeping}, 2'b01, "standby sleep");
            cmd(`ATC_OP_WEAR, 8'h00, 8'h5A, 8'h00);
            wait_irq(4);
            chk(sleeping, 1'b0, "wake by command");
            chk({sc_valid, sc_out}, 9'h100, "wear level count");
        end
    endtask

    task automatic t_xlate;
        logic [15:0] w;
        for (int p = 0; p < 2; p++) begin
            erased = (p == 0);
            hot = (p == 0) ? 24'h0D0E0F : 24'h000000;
            cmd(`ATC_OP_XLATE, 8'h00, 8'h01, 8'h56);
            for (int k = 0; k < 256; k++) begin
                host.read_word(w);
                chk(w, rpt_word(k), "report word");
            end
            wait_irq(8);
            chk(n_irq - irq_mark, 1, "report done");
        end
    endtask

    task automatic t_wrbuf;
        int s0;
        logic seen;
        s0 = n_starts;
        cmd(`ATC_OP_WRBUF, 8'h00, 8'h01, 8'h00);
        saw_busy(seen);
        chk(seen, 1'b1, "busy before drq");
        for (int k = 0; k < 256; k++) host.write_word(16'(k * 257), 1'b0);
        wait_irq(8);
        chk(n_irq - irq_mark, 1, "buffer write done");
        chk(n_starts - s0, 0, "buffer write commits nothing");
    endtask

    task automatic t_wrlong;
        logic [7:0] ops [2] = '{`ATC_OP_WRLONG_A, `ATC_OP_WRLONG_B};
        logic [7:0] e;
        int s0;
        foreach (ops[i]) begin
            s0 = n_starts;
            cmd(ops[i], 8'h00, 8'h02, 8'h40);
            for (int k = 0; k < 256; k++) host.write_word(16'hA55A ^ 16'(k), 1'b0);
            for (int k = 0; k < 4; k++) begin
                e = 8'(8'hE0 + k);
                host.write_word({~e, e}, 1'b0);
            end
            wait_irq(40);
            chk(n_irq - irq_mark, 1, "long write done");
            chk(n_starts - s0, 1, "single sector commit");
            chk(last_op, atc_pkg::ATC_MED_WRITE_LONG, "long write commit");
        end
    endtask

    task automatic t_dma(input logic [7:0] sc, input int fail_at, input int nw,
                         input logic [7:0] last_sn);
        int s0;
        int i0;
        logic seen;
        s0 = n_starts;
        err_at = s0 + fail_at;
        cmd(`ATC_OP_WRDMA, 8'h00, sc, 8'h10);
        saw_busy(seen);
        chk(seen, 1'b1, "dma busy first");
        i0 = n_irq;
        for (int k = 0; k < nw; k++) host.write_word(16'(k), 1'b1);
        wait_irq(40);
        repeat (2) @(negedge sys_clk);
        chk(n_irq - i0, 1, "single dma irq");
        chk(n_starts - s0, nw / 256, "sectors committed");
        chk({status.err, dreq}, {fail_at != 0, 1'b0}, "dma end state");
        chk({addr_cyl, addr_head, addr_sn}, {16'h1234, 4'hB, last_sn}, "dma end address");
    endtask

    task automatic t_byte;
        logic [15:0] w;
        logic [15:0] x;
        cmd(`ATC_OP_SETFEAT, `ATC_FEAT_8BIT_ON, 8'h00, 8'h00);
        wait_irq(4);
        chk(byte_mode, 1'b1, "byte mode on");
        cmd(`ATC_OP_XLATE, 8'h00, 8'h01, 8'h56);
        for (int k = 0; k < 512; k++) begin
            host.read_word(w);
            x = rpt_word(k / 2);
            chk(w, {8'h00, k[0] ? x[15:8] : x[7:0]}, "byte report");
        end
        wait_irq(8);
        chk(n_irq - irq_mark, 1, "byte report done");
        cmd(`ATC_OP_WRDMA, 8'h00, 8'h01, 8'h00);
        wait_irq(8);
        chk({status.err, err_reg, dreq}, 10'h208, "dma refused in byte mode");
        cmd(`ATC_OP_SETFEAT, `ATC_FEAT_8BIT_OFF, 8'h00, 8'h00);
        wait_irq(4);
        chk(byte_mode, 1'b0, "byte mode off");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // the full sequence needs about 100 us
    initial begin
        #800000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        chk({status, intrq, sleeping, byte_mode, dreq}, 7'h00, "reset state");
        t_standby();
        cmd(8'h00, 8'h00, 8'h00, 8'h00);
        wait_irq(4);
        chk({status.err, err_reg}, 9'h104, "unknown opcode aborted");
        t_xlate();
        t_wrbuf();
        t_wrlong();
        t_dma(8'h03, 0, 768, 8'h12);
        t_dma(8'h03, 2, 512, 8'h11);
        t_dma(8'h00, 1, 256, 8'h10);
        t_byte();
        chk(host_to, 1'b0, "host never stalled");
        print_verdict();
    end
endmodule // ata_standby_translate_write_cmds_tb
`default_nettype wire
